//--- hdl/mpwm_core.sv
// motor pwm shadowing, write-once locking and dead-time generation
// assumes pwm inputs from an external counter, synchronous to CLOCK_I
//
// Local design decisions: the address map and the plain strobed port.
`timescale 1ns/1ps
`include "mpwm_params.svh"

// Function
// - compare zero low byte, reset FFh
// - byte pair moves at update event only
// - starred bits apply at commutation/phase write
// - write preload, read active value
// - phase, enable and starred preloads copied together
// - any write locks write-once bits
// - channel count selects U only or UVW
// - dead-time enable drives complementary switch
// - enable write-once while channel count set
// - no complement only when both clear
// - output selection needs clock and master enable
// - direct six-step without enable: plain pwm
// - paired complement, side chosen by select zero
// - chopper superimposed under enable and frequency
// - mode from phase, enable, select bits
// - disabled generator gives exact complements
// - six-bit write-once dead-time field
// - dead time 125ns to 16us
module mpwm_core
  import mpwm_pkg::*;
(
  input wire logic CLOCK_I,
  input wire logic RST_N_I,
  input wire logic [3:0] ADDR_I,
  input wire logic [7:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [7:0] RDATA_O,
  input wire logic COMMUTATE_I,
  input wire logic UPDATE_I,
  input wire logic [2:0] PWM_I,
  output logic [5:0] MOTOR_OUT_O,
  output logic [11:0] CMP0_ACTIVE_O
);

  // ==========================================
  // register state
  logic [7:0] cmp0_low_pre_q;
  logic [3:0] cmp0_high_pre_q;
  logic [7:0] cmp0_low_q;
  logic [3:0] cmp0_high_q;
  logic low_written_q;
  logic high_written_q;
  mpwm_dt_s dt_q;
  logic dt_lock_q;
  mpwm_shadow_s pre_q;
  mpwm_shadow_s act_q;
  logic os0_q;
  logic moe_q;
  logic cke_q;
  logic dac_q;
  logic [1:0] hfe_q;
  logic [2:0] chopper_frequency_q;
  logic [7:0] rdata_q;

  logic wr_low;
  logic wr_high;
  logic wr_dt;
  logic wr_phase;
  logic load_shadow;

  assign wr_low = WR_I && (ADDR_I == `MPWM_OFS_CMP0_LOW);
  assign wr_high = WR_I && (ADDR_I == `MPWM_OFS_CMP0_HIGH);
  assign wr_dt = WR_I && (ADDR_I == `MPWM_OFS_DT_SETUP);
  assign wr_phase = WR_I && (ADDR_I == `MPWM_OFS_PHASE_STATE);
  // in direct access the phase write itself is the load event
  assign load_shadow = dac_q ? wr_phase : COMMUTATE_I;

  // ==========================================
  // compare zero preload pair
  always_ff @(posedge CLOCK_I) begin
    if (!RST_N_I) begin
      cmp0_low_pre_q <= `MPWM_RST_CMP0_LOW;
      cmp0_high_pre_q <= `MPWM_RST_CMP0_HIGH;
      cmp0_low_q <= `MPWM_RST_CMP0_LOW;
      cmp0_high_q <= `MPWM_RST_CMP0_HIGH;
      low_written_q <= 1'b0;
      high_written_q <= 1'b0;
    end else begin
      if (wr_low) begin
        cmp0_low_pre_q <= WDATA_I;
      end
      if (wr_high) begin
        cmp0_high_pre_q <= WDATA_I[3:0];
      end
      // a half-written pair is held back; a write in the update cycle stays pending for the next update
      if (UPDATE_I && low_written_q && high_written_q) begin
        cmp0_low_q <= cmp0_low_pre_q;
        cmp0_high_q <= cmp0_high_pre_q;
        low_written_q <= wr_low;
        high_written_q <= wr_high;
      end else begin
        low_written_q <= low_written_q | wr_low;
        high_written_q <= high_written_q | wr_high;
      end
    end
  end

  // ==========================================
  // dead-time setup with write-once locking
  always_ff @(posedge CLOCK_I) begin
    if (!RST_N_I) begin
      dt_q <= `MPWM_RST_DT_SETUP;
      dt_lock_q <= 1'b0;
    end else if (wr_dt) begin
      // the port cannot tell a bit access from a byte write, so any write locks
      dt_lock_q <= 1'b1;
      dt_q.channel_count_select <= WDATA_I[`MPWM_DT_PCN_BIT];
      if (!dt_lock_q || !dt_q.channel_count_select) begin
        dt_q.dead_time_enable <= WDATA_I[`MPWM_DT_DTE_BIT];
      end
      if (!dt_lock_q) begin
        dt_q.dead_time_value <= WDATA_I[5:0];
      end
    end
  end

  // ==========================================
  // shadowed phase state, output enables and starred control bits
  always_ff @(posedge CLOCK_I) begin
    if (!RST_N_I) begin
      pre_q <= '0;
      act_q <= '0;
    end else begin
      if (wr_phase) begin
        pre_q.phase_out <= WDATA_I[5:0];
      end
      if (WR_I && ADDR_I == `MPWM_OFS_PARITY) begin
        pre_q.out_en <= WDATA_I[5:0];
      end
      if (WR_I && ADDR_I == `MPWM_OFS_CTRL_B) begin
        pre_q.star <= {WDATA_I[`MPWM_CB_CPB_BIT], WDATA_I[`MPWM_CB_HDM_BIT],
                       WDATA_I[`MPWM_CB_SDM_BIT], WDATA_I[`MPWM_CB_OS2_BIT]};
      end
      if (load_shadow) begin
        // the phase byte written in this cycle is the one that goes live
        act_q <= pre_q;
        if (wr_phase) begin
          act_q.phase_out <= WDATA_I[5:0];
        end
      end
    end
  end

  // ==========================================
  // unshadowed control
  always_ff @(posedge CLOCK_I) begin
    if (!RST_N_I) begin
      os0_q <= 1'b0;
      moe_q <= 1'b0;
      cke_q <= 1'b0;
      dac_q <= 1'b0;
      hfe_q <= 2'h0;
      chopper_frequency_q <= 3'h0;
    end else begin
      if (WR_I && ADDR_I == `MPWM_OFS_CTRL_B) begin
        os0_q <= WDATA_I[`MPWM_CB_OS0_BIT];
      end
      if (WR_I && ADDR_I == `MPWM_OFS_CTRL_A) begin
        moe_q <= WDATA_I[`MPWM_CA_MOE_BIT];
        cke_q <= WDATA_I[`MPWM_CA_CKE_BIT];
        dac_q <= WDATA_I[`MPWM_CA_DAC_BIT];
      end
      if (WR_I && ADDR_I == `MPWM_OFS_REFERENCE) begin
        hfe_q <= WDATA_I[`MPWM_REF_HFE_HI:`MPWM_REF_HFE_LO];
        chopper_frequency_q <= WDATA_I[2:0];
      end
    end
  end

  // ==========================================
  // read port: preloaded addresses return the active copy
  always_ff @(posedge CLOCK_I) begin
    if (!RST_N_I) begin
      rdata_q <= 8'h00;
    end else if (RD_I) begin
      case (ADDR_I)
        `MPWM_OFS_CMP0_LOW: rdata_q <= cmp0_low_q;
        `MPWM_OFS_CMP0_HIGH: rdata_q <= {4'h0, cmp0_high_q};
        `MPWM_OFS_DT_SETUP: rdata_q <= dt_q;
        `MPWM_OFS_PHASE_STATE: rdata_q <= {2'h0, act_q.phase_out};
        `MPWM_OFS_PARITY: rdata_q <= {2'h0, act_q.out_en};
        `MPWM_OFS_CTRL_B: rdata_q <= {act_q.star, 3'h0, os0_q};
        `MPWM_OFS_CTRL_A: rdata_q <= {moe_q, 1'b0, cke_q, dac_q, 4'h0};
        `MPWM_OFS_REFERENCE: rdata_q <= {2'h0, hfe_q, 1'b0, chopper_frequency_q};
        default: rdata_q <= 8'h00;
      endcase
    end else begin
      rdata_q <= 8'h00;
    end
  end

  // ==========================================
  // dead-time length: 0nnnnn (n+1) steps, 10nnnn (n+17)x2, 11nnnn (n+17)x4 of 125 ns
  logic [7:0] dt_units;
  mpwm_dtcnt_t dt_cycles;
  always_comb begin
    if (!dt_q.dead_time_value[5]) begin
      dt_units = {3'h0, dt_q.dead_time_value[4:0]} + 8'h01;
    end else if (!dt_q.dead_time_value[4]) begin
      dt_units = {3'h0, 1'b1, dt_q.dead_time_value[3:0]} + 8'h01;
      dt_units = {dt_units[6:0], 1'b0};
    end else begin
      dt_units = {3'h0, 1'b1, dt_q.dead_time_value[3:0]} + 8'h01;
      dt_units = {dt_units[5:0], 2'h0};
    end
    dt_cycles = 10'(dt_units * `MPWM_DT_STEP_CYC);
  end

  // ==========================================
  // chopper: 50 % square wave at the selected frequency
  // the counter restarts while chopping is off, so the first half period is whole
  logic [7:0] chop_half;
  logic [7:0] chop_cnt_q;
  logic chop_q;
  always_comb begin
    case (chopper_frequency_q)
      3'h0: chop_half = 8'(`MPWM_HALF_CYC(`MPWM_CHOP_KHZ_0));
      3'h1: chop_half = 8'(`MPWM_HALF_CYC(`MPWM_CHOP_KHZ_1));
      3'h2: chop_half = 8'(`MPWM_HALF_CYC(`MPWM_CHOP_KHZ_2));
      3'h3: chop_half = 8'(`MPWM_HALF_CYC(`MPWM_CHOP_KHZ_3));
      3'h4: chop_half = 8'(`MPWM_HALF_CYC(`MPWM_CHOP_KHZ_4));
      3'h5: chop_half = 8'(`MPWM_HALF_CYC(`MPWM_CHOP_KHZ_5));
      3'h6: chop_half = 8'(`MPWM_HALF_CYC(`MPWM_CHOP_KHZ_6));
      default: chop_half = 8'(`MPWM_HALF_CYC(`MPWM_CHOP_KHZ_7));
    endcase
  end

  always_ff @(posedge CLOCK_I) begin
    if (!RST_N_I) begin
      chop_cnt_q <= 8'h00;
      chop_q <= 1'b0;
    end else if (hfe_q == 2'h0) begin
      chop_cnt_q <= 8'h00;
      chop_q <= 1'b0;
    end else if (chop_cnt_q >= chop_half - 8'h01) begin
      chop_cnt_q <= 8'h00;
      chop_q <= ~chop_q;
    end else begin
      chop_cnt_q <= chop_cnt_q + 8'h01;
    end
  end

  // ==========================================
  // per-phase source select and dead-time insertion
  logic comp_mode;
  logic out_live;
  logic [5:0] chan_d;
  logic [5:0] out_q;
  // complement is missing only with both bits clear, whatever the access mode
  assign comp_mode = dt_q.channel_count_select | dt_q.dead_time_enable;
  assign out_live = cke_q & moe_q;

  genvar ph;
  generate
    for (ph = 0; ph < 3; ph++) begin : g_phase
      logic src;
      logic src_q;
      logic hi_q;
      logic lo_q;
      mpwm_dtcnt_t cnt_q;
      logic pair_on;
      logic side_hi;
      logic side_lo;
      logic plain_hi;
      logic plain_lo;

      assign src = dt_q.channel_count_select ? PWM_I[ph] : PWM_I[0];

      // an edge inside the dead time restarts the count, so short pulses never pass
      always_ff @(posedge CLOCK_I) begin
        if (!RST_N_I) begin
          src_q <= 1'b0;
          hi_q <= 1'b0;
          lo_q <= 1'b1;
          cnt_q <= '0;
        end else begin
          src_q <= src;
          if (!dt_q.dead_time_enable) begin
            // zero dead time: exact complements, external dead time assumed
            hi_q <= src;
            lo_q <= ~src;
            cnt_q <= '0;
          end else if (src != src_q) begin
            hi_q <= 1'b0;
            lo_q <= 1'b0;
            cnt_q <= dt_cycles;
          end else if (cnt_q > 10'd1) begin
            cnt_q <= cnt_q - 10'd1;
          end else begin
            hi_q <= src_q;
            lo_q <= ~src_q;
            cnt_q <= '0;
          end
        end
      end

      // paired mode: pwm side chosen by select zero, other side its complement
      assign pair_on = act_q.phase_out[2*ph] | act_q.phase_out[2*ph+1];
      assign side_hi = pair_on & (os0_q ? lo_q : hi_q);
      assign side_lo = pair_on & (os0_q ? hi_q : lo_q);
      // plain mode: enabled channels carry pwm on the side picked by select two
      assign plain_hi = act_q.phase_out[2*ph] &
                        ((act_q.out_en[2*ph] && !act_q.star.os2) ? src : 1'b1);
      assign plain_lo = act_q.phase_out[2*ph+1] &
                        ((act_q.out_en[2*ph+1] && act_q.star.os2) ? src : 1'b1);

      always_comb begin
        if (comp_mode) begin
          chan_d[2*ph] = side_hi & (hfe_q[1] ? chop_q : 1'b1);
          chan_d[2*ph+1] = side_lo & (hfe_q[0] ? chop_q : 1'b1);
        end else begin
          chan_d[2*ph] = plain_hi & (hfe_q[1] ? chop_q : 1'b1);
          chan_d[2*ph+1] = plain_lo & (hfe_q[0] ? chop_q : 1'b1);
        end
      end
    end
  endgenerate

  always_ff @(posedge CLOCK_I) begin
    if (!RST_N_I) begin
      out_q <= 6'h00;
    end else begin
      out_q <= out_live ? chan_d : 6'h00;
    end
  end

  assign MOTOR_OUT_O = out_q;
  assign RDATA_O = rdata_q;
  assign CMP0_ACTIVE_O = {cmp0_high_q, cmp0_low_q};

endmodule // mpwm_core

//--- hdl/mpwm_params.svh
// register offsets, field positions, reset values and timing counts of the motor pwm block
// assumes an 8-bit register port and a 40 MHz peripheral clock
`ifndef MPWM_PARAMS_SVH
`define MPWM_PARAMS_SVH

// ==========================================
// register offsets
`define MPWM_OFS_CMP0_LOW 4'h0
`define MPWM_OFS_CMP0_HIGH 4'h1
`define MPWM_OFS_DT_SETUP 4'h2
`define MPWM_OFS_PHASE_STATE 4'h3
`define MPWM_OFS_CTRL_B 4'h4
`define MPWM_OFS_PARITY 4'h5
`define MPWM_OFS_CTRL_A 4'h6
`define MPWM_OFS_REFERENCE 4'h7

// ==========================================
// reset values
`define MPWM_RST_CMP0_LOW 8'hFF
`define MPWM_RST_CMP0_HIGH 4'hF
`define MPWM_RST_DT_SETUP 8'hFF

// ==========================================
// field positions
`define MPWM_DT_PCN_BIT 7
`define MPWM_DT_DTE_BIT 6
`define MPWM_CB_CPB_BIT 7
`define MPWM_CB_HDM_BIT 6
`define MPWM_CB_SDM_BIT 5
`define MPWM_CB_OS2_BIT 4
`define MPWM_CB_OS0_BIT 0
`define MPWM_CA_MOE_BIT 7
`define MPWM_CA_CKE_BIT 5
`define MPWM_CA_DAC_BIT 4
`define MPWM_REF_HFE_HI 5
`define MPWM_REF_HFE_LO 4

// ==========================================
// timing
`define MPWM_CLK_MHZ 40
`define MPWM_DT_STEP_NS 125
`define MPWM_DT_STEP_CYC (((`MPWM_DT_STEP_NS) * (`MPWM_CLK_MHZ) + 999) / 1000)
`define MPWM_CHOP_KHZ_0 100
`define MPWM_CHOP_KHZ_1 200
`define MPWM_CHOP_KHZ_2 400
`define MPWM_CHOP_KHZ_3 500
`define MPWM_CHOP_KHZ_4 800
`define MPWM_CHOP_KHZ_5 1000
`define MPWM_CHOP_KHZ_6 1333
`define MPWM_CHOP_KHZ_7 2000
`define MPWM_HALF_CYC(khz) ((`MPWM_CLK_MHZ) * 500 / (khz))

`endif

//--- hdl/mpwm_pkg.sv
// types shared by the motor pwm block
// assumes mpwm_params.svh for all numeric constants
package mpwm_pkg;

  typedef struct packed {
    logic compare_polarity_bit;
    logic hardware_demag_bit;
    logic simulated_demag_bit;
    logic os2;
  } mpwm_star_s;

  typedef struct packed {
    logic channel_count_select;
    logic dead_time_enable;
    logic [5:0] dead_time_value;
  } mpwm_dt_s;

  typedef struct packed {
    logic [5:0] phase_out;
    logic [5:0] out_en;
    mpwm_star_s star;
  } mpwm_shadow_s;

  typedef logic [9:0] mpwm_dtcnt_t;

endpackage

//--- verification/mpwm_chk.sv
// assertions on the motor pwm core ports: register port, locks, shadows, outputs
// assumes it is bound onto mpwm_core and sees every port of it
`timescale 1ns/1ps
module mpwm_chk
  import mpwm_pkg::*;
(
  input wire logic CLOCK_I,
  input wire logic RST_N_I,
  input wire logic [3:0] ADDR_I,
  input wire logic [7:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  input wire logic [7:0] RDATA_O,
  input wire logic COMMUTATE_I,
  input wire logic UPDATE_I,
  input wire logic [2:0] PWM_I,
  input wire logic [5:0] MOTOR_OUT_O,
  input wire logic [11:0] CMP0_ACTIVE_O
);
  default clocking @(posedge CLOCK_I); endclocking
  default disable iff (!RST_N_I);
  // ==========
  // copies of what software wrote
  logic [7:0] dt_q, ca_q, dtp_q;
  logic [5:0] pre_q, act_q, psp_q;
  logic [2:0] cnt_q;
  logic lk_q;
  wire ok = ca_q[7] && ca_q[5];
  always_ff @(posedge CLOCK_I) begin
    if (!RST_N_I) begin
      dt_q <= 8'hFF;
      lk_q <= 1'h0;
    end else if (WR_I && ADDR_I == 4'h2) begin
      dt_q[7] <= WDATA_I[7];
      if (!lk_q || !dt_q[7]) dt_q[6] <= WDATA_I[6];
      if (!lk_q) dt_q[5:0] <= WDATA_I[5:0];
      lk_q <= 1'h1;
    end
  end
  always_ff @(posedge CLOCK_I) begin
    if (!RST_N_I) ca_q <= 8'h00;
    else if (WR_I && ADDR_I == 4'h6) ca_q <= WDATA_I;
  end
  always_ff @(posedge CLOCK_I) begin
    if (!RST_N_I) begin
      pre_q <= 6'h00;
      act_q <= 6'h00;
    end else begin
      if (WR_I && ADDR_I == 4'h3) pre_q <= WDATA_I[5:0];
      if (WR_I && ADDR_I == 4'h3 && (ca_q[4] || COMMUTATE_I)) act_q <= WDATA_I[5:0];
      else if (COMMUTATE_I && !ca_q[4]) act_q <= pre_q;
    end
  end
  // read data lag one cycle behind the register they show
  always_ff @(posedge CLOCK_I) begin
    dtp_q <= dt_q;
    psp_q <= act_q;
  end
  // settle count: outputs lag the registers, so judge them only once quiet
  always_ff @(posedge CLOCK_I) begin
    if (!RST_N_I || WR_I || !ok) cnt_q <= 3'h0;
    else if (cnt_q != 3'h7) cnt_q <= cnt_q + 3'h1;
  end
  // ==========
  // properties
  sequence s_low_drop;
    cnt_q == 3'h7 && dt_q[6] ##0 $fell(MOTOR_OUT_O[1]);
  endsequence
  sequence s_high_wait;
    !MOTOR_OUT_O[0] [*4];
  endsequence
  a_rd_quiet: assert property (!$past(RD_I) |-> RDATA_O == 8'h00)
    else $error("read data outside its cycle");
  a_cmp_reset: assert property ($rose(RST_N_I) |-> CMP0_ACTIVE_O == 12'hFFF)
    else $error("compare zero not all ones after reset");
  a_cmp_hold: assert property ($past(RST_N_I) && !$past(UPDATE_I) |-> $stable(CMP0_ACTIVE_O))
    else $error("compare zero moved without update");
  a_dtg_lock: assert property (RD_I && ADDR_I == 4'h2 |=> RDATA_O[5:0] == dtp_q[5:0])
    else $error("dead time field changed after lock");
  a_dte_lock: assert property (RD_I && ADDR_I == 4'h2 |=> RDATA_O[7:6] == dtp_q[7:6])
    else $error("dead time enable or count wrong");
  a_shadow_read: assert property (RD_I && ADDR_I == 4'h3 |=> RDATA_O == {2'h0, psp_q})
    else $error("phase state read not the active value");
  a_out_gate: assert property (!ok && !$past(ok) && !$past(ok, 2) |-> MOTOR_OUT_O == 6'h00)
    else $error("outputs live without clock and master enable");
  a_comp_exact: assert property (cnt_q == 3'h7 && dt_q[7:6] == 2'h2 |->
    (MOTOR_OUT_O[1] ^ MOTOR_OUT_O[0]) && (MOTOR_OUT_O[3] ^ MOTOR_OUT_O[2]))
    else $error("pair not exactly complemented");
  a_dt_gap: assert property (s_low_drop |-> s_high_wait)
    else $error("high side rose inside dead time");
endmodule // mpwm_chk

bind mpwm_core mpwm_chk u_chk (.CLOCK_I(CLOCK_I), .RST_N_I(RST_N_I), .ADDR_I(ADDR_I),
  .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O), .COMMUTATE_I(COMMUTATE_I),
  .UPDATE_I(UPDATE_I), .PWM_I(PWM_I), .MOTOR_OUT_O(MOTOR_OUT_O), .CMP0_ACTIVE_O(CMP0_ACTIVE_O));

//--- verification/mpwm_inv.sv
// inverter leg model: counts cycles in which both switches of a leg conduct
// assumes channel 2p is the high side and 2p+1 the low side of leg p
`timescale 1ns/1ps
module mpwm_inv (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [5:0] gate_i,
  output logic [7:0] shoot_o
);
  // ==========
  // shoot-through counter, saturating so it never wraps back to zero
  wire [2:0] both = {gate_i[5] & gate_i[4], gate_i[3] & gate_i[2], gate_i[1] & gate_i[0]};
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) shoot_o <= 8'h00;
    else if (|both && shoot_o != 8'hFF) shoot_o <= shoot_o + 8'h01;
  end
endmodule // mpwm_inv

//--- verification/tb_top.sv
// self-checking bench for mpwm_core: register port, preloads, locks, dead time
// assumes the checker bind and the inverter model are compiled before it
`timescale 1ns/1ps
module tb_top;
  import mpwm_pkg::*;
  logic clk, rst_n, wr, rd, com, upd, lk;
  logic [3:0] addr;
  logic [7:0] wd, rdat, edt, shoot;
  logic [2:0] pwm;
  logic [5:0] mo;
  logic [11:0] cmp, ecmp;
  logic [31:0] lf;
  logic [7:0] wv [6] = '{8'h40, 8'h3F, 8'hC0, 8'h80, 8'h00, 8'h00};
  int failures, comparisons, cyc;
  int ones, tgl;
  logic prv;
  mpwm_core DUT (.CLOCK_I(clk), .RST_N_I(rst_n), .ADDR_I(addr), .WDATA_I(wd), .WR_I(wr),
    .RD_I(rd), .RDATA_O(rdat), .COMMUTATE_I(com), .UPDATE_I(upd), .PWM_I(pwm),
    .MOTOR_OUT_O(mo), .CMP0_ACTIVE_O(cmp));
  mpwm_inv u_inv (.clk_i(clk), .rst_n_i(rst_n), .gate_i(mo), .shoot_o(shoot));
  initial begin
    clk = 1'h0;
    forever #12.5 clk = ~clk;
  end
  // ==========
  // helpers
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [7:0] dt_next(input logic [7:0] o, input logic l, input logic [7:0] w);
    return {w[7], (l && o[7]) ? o[6] : w[6], l ? o[5:0] : w[5:0]};
  endfunction
  task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    if (failures == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk);
    addr <= a;
    wd <= v;
    wr <= 1'h1;
    @(posedge clk);
    wr <= 1'h0;
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'h1;
    @(posedge clk);
    rd <= 1'h0;
    #1;
    chk(12'(rdat), 12'(e));
  endtask
  task automatic ev(input logic u);
    @(posedge clk);
    upd <= u;
    com <= ~u;
    @(posedge clk);
    upd <= 1'h0;
    com <= 1'h0;
    #1;
  endtask
  // pwm held long enough for any short dead time to run out before the pins are read
  task automatic pw_chk(input logic [2:0] p, input logic [5:0] e);
    @(posedge clk);
    pwm <= p;
    repeat (8) @(posedge clk);
    #1;
    chk(12'(mo), 12'(e));
  endtask
  // short random holds make pwm edges land inside the dead time too
  task automatic run(input int n);
    int k;
    k = 0;
    repeat (n) begin
      @(posedge clk);
      if (k == 0) begin
        lf = nxt(lf);
        pwm <= lf[2:0];
        k = lf[6:3];
      end else begin
        k--;
      end
    end
    #1;
  endtask
  task automatic reset();
    @(posedge clk);
    rst_n <= 1'h0;
    repeat (5) @(posedge clk);
    rst_n <= 1'h1;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      failures++;
      complete_run();
    end
  end
  // ==========
  // scenarios
  initial begin
    {rst_n, wr, rd, com, upd, lk} = 6'h00;
    addr = 4'h0;
    wd = 8'h00;
    pwm = 3'h0;
    lf = 32'hAA31;
    ecmp = 12'hFFF;
    edt = 8'hFF;
    repeat (5) @(posedge clk);
    rst_n <= 1'h1;
    #1;
    chk(cmp, 12'hFFF);
    run(40);
    chk(12'(mo), 12'h000);
    rd_chk(4'h0, 8'hFF);
    rd_chk(4'hC, 8'h00);
    for (int i = 0; i < 6; i++) begin
      lf = nxt(lf);
      wr_reg(4'h0, lf[7:0]);
      if (i != 2) wr_reg(4'h1, {4'h0, lf[11:8]});
      rd_chk(4'h0, ecmp[7:0]);
      ev(1'h1);
      if (i != 2) ecmp = lf[11:0];
      chk(cmp, ecmp);
    end
    foreach (wv[i]) begin
      wr_reg(4'h2, wv[i]);
      edt = dt_next(edt, lk, wv[i]);
      lk = 1'h1;
      rd_chk(4'h2, edt);
    end
    wr_reg(4'h6, 8'hA0);
    wr_reg(4'h3, 8'h15);
    rd_chk(4'h3, 8'h00);
    ev(1'h0);
    rd_chk(4'h3, 8'h15);
    wr_reg(4'h6, 8'hB0);
    wr_reg(4'h3, 8'h2A);
    rd_chk(4'h3, 8'h2A);
    reset();
    wr_reg(4'h2, 8'h40);
    wr_reg(4'h6, 8'hB0);
    wr_reg(4'h3, 8'h03);
    run(400);
    chk(12'(shoot), 12'h000);
    wr_reg(4'h4, 8'h01);
    pw_chk(3'h1, 6'h02);
    pw_chk(3'h0, 6'h01);
    reset();
    wr_reg(4'h2, 8'h80);
    wr_reg(4'h6, 8'hB0);
    wr_reg(4'h3, 8'h3F);
    run(400);
    chk(12'(shoot), 12'h000);
    reset();
    wr_reg(4'h2, 8'hC5);
    wr_reg(4'h6, 8'hB0);
    wr_reg(4'h3, 8'h3F);
    run(400);
    chk(12'(shoot), 12'h000);
    // plain six-step: U high carries pwm, V low static, then V low carries pwm under select two
    reset();
    wr_reg(4'h2, 8'h00);
    wr_reg(4'h6, 8'hB0);
    wr_reg(4'h5, 8'h01);
    wr_reg(4'h3, 8'h09);
    pw_chk(3'h0, 6'h08);
    pw_chk(3'h1, 6'h09);
    wr_reg(4'h5, 8'h08);
    wr_reg(4'h4, 8'h10);
    pw_chk(3'h0, 6'h08);
    wr_reg(4'h3, 8'h09);
    pw_chk(3'h0, 6'h01);
    pw_chk(3'h1, 6'h09);
    // chop high sides at the fastest rate: 20-cycle period, half of it on
    wr_reg(4'h7, 8'h27);
    repeat (4) @(posedge clk);
    #1;
    ones = 0;
    tgl = 0;
    prv = mo[0];
    repeat (40) begin
      @(posedge clk);
      #1;
      ones += mo[0];
      tgl += (mo[0] != prv);
      prv = mo[0];
    end
    chk(12'(ones), 12'h014);
    chk(12'(tgl), 12'h004);
    chk(12'(mo[3]), 12'h001);
    complete_run();
  end
endmodule // tb_top
